// *** design/rtcrb_params.svh ***
// Purpose: Constants of the real-time clock register bank
// Assumes: Byte-wide registers, 16 addresses, 10 MHz core clock
// Notes:   Definitions only
`ifndef RTCRB_PARAMS_SVH
`define RTCRB_PARAMS_SVH

// Clock and time base
`define RTCRB_CLK_HZ        10000000
`define RTCRB_TICK_HZ       100
`define RTCRB_TICK_CYCLES   (`RTCRB_CLK_HZ / `RTCRB_TICK_HZ)
`define RTCRB_DIV_W         17

// Addresses
`define RTCRB_ADDR_SUBSEC   4'h0
`define RTCRB_ADDR_SECONDS  4'h1
`define RTCRB_ADDR_MINUTES  4'h2
`define RTCRB_ADDR_HOURS    4'h3
`define RTCRB_ADDR_WEEKDAY  4'h4
`define RTCRB_ADDR_DATE     4'h5
`define RTCRB_ADDR_MONTH    4'h6
`define RTCRB_ADDR_YEAR     4'h7
`define RTCRB_ADDR_TRIM     4'h8
`define RTCRB_ADDR_WDOG     4'h9
`define RTCRB_ADDR_ALMONTH  4'hA
`define RTCRB_ADDR_ALDAY    4'hB
`define RTCRB_ADDR_ALHOUR   4'hC
`define RTCRB_ADDR_ALMIN    4'hD
`define RTCRB_ADDR_ALSEC    4'hE
`define RTCRB_ADDR_FLAGS    4'hF

// Field positions
`define RTCRB_BIT_HALT      7
`define RTCRB_BIT_OSC_FAIL_IRQ_ENABLE      7
`define RTCRB_BIT_CB_HI     7
`define RTCRB_BIT_CB_LO     6
`define RTCRB_BIT_OUTLVL    7
`define RTCRB_BIT_FTEST     6
`define RTCRB_BIT_WDF       7
`define RTCRB_BIT_AF        6
`define RTCRB_BIT_OF        2
`define RTCRB_BIT_APE       7
`define RTCRB_BIT_SQUARE_WAVE_ENABLE      6
`define RTCRB_BIT_LFOE      5
`define RTCRB_BIT_RPT_HI    7
`define RTCRB_BIT_RPT5      6

// Implemented bits per address, address 15 in the top byte
`define RTCRB_MASK_SQW      128'hC4FFFFBF_FF7FFF3F_FFDF3FF7_3F7FFFFF
`define RTCRB_MASK_APIN     128'hC4FFFFBF_FF9FFFFF_FFDF3F07_3FFFFFFF

// BCD ranges and reset values
`define RTCRB_MAX_SUBSEC    8'h99
`define RTCRB_MAX_MINSEC    8'h59
`define RTCRB_MAX_HOUR      8'h23
`define RTCRB_MIN_ONE       8'h01
`define RTCRB_MIN_ZERO      8'h00
`define RTCRB_MAX_WEEKDAY   8'h07
`define RTCRB_MAX_DATE      8'h31
`define RTCRB_MAX_MONTH     8'h12
`define RTCRB_MAX_YEAR      8'h99
`define RTCRB_KEEP_SEC      8'h80
`define RTCRB_KEEP_HOUR     8'hC0
`define RTCRB_KEEP_WEEKDAY  8'hF8
`define RTCRB_KEEP_DATE     8'hC0
`define RTCRB_KEEP_MONTH    8'hE0
`define RTCRB_RST_ONE       8'h01

`endif

// *** design/rtcrb_pkg.sv ***
// Purpose: Types of the real-time clock register bank
// Assumes: rtcrb_params.svh supplies the widths
// Notes:   Whole module state is one packed struct
`include "rtcrb_params.svh"
`default_nettype none
package rtcrb_pkg;

  typedef struct packed {
    logic                       busy;
    logic                       dirty;
    logic [3:0]                 ptr;
    logic [`RTCRB_DIV_W-1:0]    div;
    logic [7:0][7:0]            cnt;
    logic [7:0][7:0]            shadow;
    logic [14:8][7:0]           bank;
    logic                       af;
    logic                       watchdog_expired_flag;
    logic                       of;
    logic [7:0]                 rdData;
    logic                       rdValid;
    logic [3:0]                 rdAddr;
  } rtcrb_state_t;

endpackage
`default_nettype wire

// *** design/rtcrb_register_bank.sv ***
// Purpose: Sixteen-byte register bank of a real-time clock with BCD counters
// Assumes: Byte port driven by the serial front end on core_clk, one strobe a cycle
// Notes:   APIN_VARIANT selects the alarm-pin map, else the square-wave map
`include "rtcrb_params.svh"
`default_nettype none
module rtcrb_register_bank #(
  parameter bit APIN_VARIANT = 1'b0,
  parameter int TICK_CYCLES  = `RTCRB_TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        accStart,
  input  wire logic        accStop,
  input  wire logic        ptrLoad,
  input  wire logic [3:0]  ptrValue,
  input  wire logic        wrStrobe,
  input  wire logic [7:0]  wrData,
  input  wire logic        rdStrobe,
  output logic [7:0]       rdData,
  output logic             rdValid,
  input  wire logic        alarmMatchEvt,
  input  wire logic        watchdogExpireEvt,
  input  wire logic        oscFailEvt,
  output logic             oscillatorHalt,
  output logic             oscFailIrqEnable,
  output logic [3:0]       squareWaveRate,
  output logic [1:0]       centuryCount,
  output logic             frequencyTest,
  output logic             outputLevel,
  output logic [2:0]       watchdogTickSelect,
  output logic [4:0]       watchdogCountMultiplier,
  output logic             squareWaveEnable,
  output logic             fixedLowFreqOutputEnable,
  output logic             alarmPinEnable,
  output logic [5:1]       alarmRepeatMask,
  output logic             alarmMatchFlag,
  output logic             watchdogExpiredFlag,
  output logic             oscillatorFailFlag
);

  localparam logic [127:0] MAP_MASK = APIN_VARIANT ? `RTCRB_MASK_APIN : `RTCRB_MASK_SQW;
  localparam logic [`RTCRB_DIV_W-1:0] TICK_LAST = `RTCRB_DIV_W'(TICK_CYCLES - 1);

  rtcrb_pkg::rtcrb_state_t st_q;
  rtcrb_pkg::rtcrb_state_t st_d;
  logic       tick;
  logic       transfer;
  logic [7:0] accMask;
  logic [7:0] rdByte;
  logic [5:0] carry;

  // Implemented bits of one address in the chosen map
  function automatic logic [7:0] mapMask(input logic [3:0] a);
    mapMask = MAP_MASK[{a, 3'h0} +: 8];
  endfunction

  // BCD count of the unkept bits, wrapping from hi back to lo
  function automatic logic [7:0] bcdStep(input logic [7:0] v, input logic [7:0] keep,
                                         input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] f;
    f = v & ~keep;
    if (f == hi) begin
      f = lo;
    end else if (f[3:0] == 4'h9) begin
      f = {f[7:4] + 4'h1, 4'h0};
    end else begin
      f = f + 8'h01;
    end
    bcdStep = (v & keep) | f;
  endfunction

  // Read view: frozen time copy, direct bank, or flags
  always_comb begin
    accMask = mapMask(st_q.ptr);
    if (st_q.ptr == `RTCRB_ADDR_FLAGS) begin
      rdByte = 8'h00;
      rdByte[`RTCRB_BIT_WDF] = st_q.watchdog_expired_flag;
      rdByte[`RTCRB_BIT_AF]  = st_q.af;
      rdByte[`RTCRB_BIT_OF]  = st_q.of;
    end else if (!st_q.ptr[3]) begin
      rdByte = st_q.shadow[st_q.ptr[2:0]];
    end else begin
      rdByte = st_q.bank[st_q.ptr];
    end
    rdByte = rdByte & accMask;
  end

  // Whole next-state function
  always_comb begin
    st_d = st_q;
    st_d.rdValid = 1'b0;
    tick = 1'b0;
    transfer = 1'b0;
    carry = 6'h00;
    if (accStart) begin
      st_d.busy = 1'b1;
    end
    if (accStop) begin
      st_d.busy = 1'b0;
    end
    // Time base; a halted oscillator never ticks
    if (st_q.cnt[1][`RTCRB_BIT_HALT]) begin
      st_d.div = '0;
    end else if (st_q.div == TICK_LAST) begin
      st_d.div = '0;
      tick = 1'b1;
    end else begin
      st_d.div = st_q.div + `RTCRB_DIV_W'(1);
    end
    // Ripple through the BCD counters
    if (tick) begin
      carry[0] = st_q.cnt[0] == `RTCRB_MAX_SUBSEC;
      carry[1] = carry[0] && ((st_q.cnt[1] & ~`RTCRB_KEEP_SEC) == `RTCRB_MAX_MINSEC);
      carry[2] = carry[1] && ((st_q.cnt[2] & ~`RTCRB_KEEP_SEC) == `RTCRB_MAX_MINSEC);
      carry[3] = carry[2] && ((st_q.cnt[3] & ~`RTCRB_KEEP_HOUR) == `RTCRB_MAX_HOUR);
      carry[4] = carry[3] && ((st_q.cnt[5] & ~`RTCRB_KEEP_DATE) == `RTCRB_MAX_DATE);
      carry[5] = carry[4] && ((st_q.cnt[6] & ~`RTCRB_KEEP_MONTH) == `RTCRB_MAX_MONTH);
      st_d.cnt[0] = bcdStep(st_q.cnt[0], 8'h00, `RTCRB_MIN_ZERO, `RTCRB_MAX_SUBSEC);
      if (carry[0]) begin
        st_d.cnt[1] = bcdStep(st_q.cnt[1], `RTCRB_KEEP_SEC, `RTCRB_MIN_ZERO,
                              `RTCRB_MAX_MINSEC);
      end
      if (carry[1]) begin
        st_d.cnt[2] = bcdStep(st_q.cnt[2], `RTCRB_KEEP_SEC, `RTCRB_MIN_ZERO,
                              `RTCRB_MAX_MINSEC);
      end
      if (carry[2]) begin
        st_d.cnt[3] = bcdStep(st_q.cnt[3], `RTCRB_KEEP_HOUR, `RTCRB_MIN_ZERO,
                              `RTCRB_MAX_HOUR);
      end
      if (carry[3]) begin
        st_d.cnt[4] = bcdStep(st_q.cnt[4], `RTCRB_KEEP_WEEKDAY, `RTCRB_MIN_ONE,
                              `RTCRB_MAX_WEEKDAY);
        st_d.cnt[5] = bcdStep(st_q.cnt[5], `RTCRB_KEEP_DATE, `RTCRB_MIN_ONE,
                              `RTCRB_MAX_DATE);
      end
      if (carry[4]) begin
        st_d.cnt[6] = bcdStep(st_q.cnt[6], `RTCRB_KEEP_MONTH, `RTCRB_MIN_ONE,
                              `RTCRB_MAX_MONTH);
      end
      if (carry[5]) begin
        st_d.cnt[7] = bcdStep(st_q.cnt[7], 8'h00, `RTCRB_MIN_ZERO, `RTCRB_MAX_YEAR);
        // Century wraps 3 to 0 with the year
        if (st_q.cnt[7] == `RTCRB_MAX_YEAR) begin
          st_d.cnt[6][`RTCRB_BIT_CB_HI:`RTCRB_BIT_CB_LO] =
            st_d.cnt[6][`RTCRB_BIT_CB_HI:`RTCRB_BIT_CB_LO] + 2'h1;
        end
      end
    end
    // Copy follows the counters only while no access is open
    if (!st_q.busy && !accStart) begin
      st_d.shadow = st_d.cnt;
    end
    // Byte port; pointer load wins over a strobe in the same cycle
    if (ptrLoad) begin
      st_d.ptr = ptrValue;
    end else if (wrStrobe) begin
      if (!st_q.ptr[3]) begin
        // Host may write ones into fixed zeros; masking keeps them clear
        st_d.shadow[st_q.ptr[2:0]] = wrData & accMask;
        if (st_q.ptr == `RTCRB_ADDR_SUBSEC) begin
          st_d.shadow[0] = 8'h00;
        end
        st_d.dirty = 1'b1;
      end else if (st_q.ptr == `RTCRB_ADDR_FLAGS) begin
        // Only the fail flag can be cleared by writing zero
        if (!wrData[`RTCRB_BIT_OF]) begin
          st_d.of = 1'b0;
        end
      end else begin
        st_d.bank[st_q.ptr] = wrData & accMask;
      end
      st_d.ptr = st_q.ptr + 4'h1;
      transfer = st_q.ptr == `RTCRB_ADDR_YEAR;
    end else if (rdStrobe) begin
      st_d.rdData = rdByte;
      st_d.rdValid = 1'b1;
      st_d.rdAddr = st_q.ptr;
      // Reading the flags clears the two event flags
      if (st_q.ptr == `RTCRB_ADDR_FLAGS) begin
        st_d.af = 1'b0;
        st_d.watchdog_expired_flag = 1'b0;
      end
      st_d.ptr = st_q.ptr + 4'h1;
    end
    // A write to the year byte, or a stop with a time write pending, loads all counters at once
    if ((transfer || accStop) && st_d.dirty) begin
      transfer = 1'b1;
      st_d.cnt = st_d.shadow;
      st_d.cnt[0] = 8'h00;
      st_d.div = '0;
      st_d.dirty = 1'b0;
    end else begin
      transfer = 1'b0;
    end
    // Events set after any clear so a same-cycle event survives
    if (alarmMatchEvt) begin
      st_d.af = 1'b1;
    end
    if (watchdogExpireEvt) begin
      st_d.watchdog_expired_flag = 1'b1;
    end
    if (oscFailEvt) begin
      st_d.of = 1'b1;
    end
  end

  // State register; calendar starts at day 1 of month 1
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.cnt[4] <= `RTCRB_RST_ONE;
      st_q.cnt[5] <= `RTCRB_RST_ONE;
      st_q.cnt[6] <= `RTCRB_RST_ONE;
      st_q.shadow[4] <= `RTCRB_RST_ONE;
      st_q.shadow[5] <= `RTCRB_RST_ONE;
      st_q.shadow[6] <= `RTCRB_RST_ONE;
    end else begin
      st_q <= st_d;
    end
  end

  // Field outputs straight from stored bytes
  assign rdData = st_q.rdData;
  assign rdValid = st_q.rdValid;
  assign oscillatorHalt = st_q.cnt[1][`RTCRB_BIT_HALT];
  assign oscFailIrqEnable = st_q.cnt[2][`RTCRB_BIT_OSC_FAIL_IRQ_ENABLE];
  assign squareWaveRate = st_q.cnt[4][7:4];
  assign centuryCount = st_q.cnt[6][`RTCRB_BIT_CB_HI:`RTCRB_BIT_CB_LO];
  assign outputLevel = st_q.bank[8][`RTCRB_BIT_OUTLVL];
  assign frequencyTest = st_q.bank[8][`RTCRB_BIT_FTEST];
  assign watchdogTickSelect = {st_q.bank[9][7], st_q.bank[9][1:0]};
  assign watchdogCountMultiplier = st_q.bank[9][6:2];
  assign alarmPinEnable = st_q.bank[10][`RTCRB_BIT_APE];
  assign squareWaveEnable = st_q.bank[10][`RTCRB_BIT_SQUARE_WAVE_ENABLE];
  assign fixedLowFreqOutputEnable = st_q.bank[10][`RTCRB_BIT_LFOE];
  // Repeat mask order 5,4,3,2,1
  assign alarmRepeatMask = {st_q.bank[11][`RTCRB_BIT_RPT5], st_q.bank[11][`RTCRB_BIT_RPT_HI],
                            st_q.bank[12][`RTCRB_BIT_RPT_HI], st_q.bank[13][`RTCRB_BIT_RPT_HI],
                            st_q.bank[14][`RTCRB_BIT_RPT_HI]};
  assign alarmMatchFlag = st_q.af;
  assign watchdogExpiredFlag = st_q.watchdog_expired_flag;
  assign oscillatorFailFlag = st_q.of;

  // Checks
  property p_afReadOnly;
    @(posedge core_clk) disable iff (!rstn)
      (wrStrobe && !ptrLoad && st_q.ptr == `RTCRB_ADDR_FLAGS && !st_q.af && !alarmMatchEvt)
      |=> !alarmMatchFlag;
  endproperty
  a_afReadOnly: assert property (p_afReadOnly) else $error("alarm flag set by a write");

  property p_wdfReadOnly;
    @(posedge core_clk) disable iff (!rstn)
      (wrStrobe && !ptrLoad && st_q.ptr == `RTCRB_ADDR_FLAGS && !st_q.watchdog_expired_flag && !watchdogExpireEvt)
      |=> !watchdogExpiredFlag;
  endproperty
  a_wdfReadOnly: assert property (p_wdfReadOnly) else $error("watchdog flag set by write");

  property p_flagsLayout;
    @(posedge core_clk) disable iff (!rstn)
      (rdStrobe && !ptrLoad && !wrStrobe && st_q.ptr == `RTCRB_ADDR_FLAGS && !oscFailEvt)
      |=> rdValid && rdData[`RTCRB_BIT_OF] == $past(st_q.of) && (rdData & 8'h3B) == 8'h00;
  endproperty
  a_flagsLayout: assert property (p_flagsLayout) else $error("flags byte layout wrong");

  property p_wdogFields;
    @(posedge core_clk) disable iff (!rstn)
      (wrStrobe && !ptrLoad && st_q.ptr == `RTCRB_ADDR_WDOG)
      |=> watchdogCountMultiplier == $past(wrData[6:2])
          && watchdogTickSelect == {$past(wrData[7]), $past(wrData[1:0])};
  endproperty
  a_wdogFields: assert property (p_wdogFields) else $error("watchdog fields misplaced");

  property p_repeatMask;
    @(posedge core_clk) disable iff (!rstn)
      (wrStrobe && !ptrLoad && st_q.ptr == `RTCRB_ADDR_ALDAY)
      |=> alarmRepeatMask[5:4] == {$past(wrData[6]), $past(wrData[7])};
  endproperty
  a_repeatMask: assert property (p_repeatMask) else $error("repeat mask misplaced");

  property p_transferLoad;
    @(posedge core_clk) disable iff (!rstn)
      transfer |=> centuryCount == st_q.shadow[6][7:6] && st_q.cnt[0] == 8'h00 && !st_q.dirty;
  endproperty
  a_transferLoad: assert property (p_transferLoad) else $error("buffered load failed");

  property p_frozenCopy;
    @(posedge core_clk) disable iff (!rstn)
      (st_q.busy && !accStop && !wrStrobe) ##1 (st_q.busy && !accStop && !wrStrobe)
      |=> $stable(st_q.shadow);
  endproperty
  a_frozenCopy: assert property (p_frozenCopy) else $error("time copy moved in access");

  property p_haltStops;
    @(posedge core_clk) disable iff (!rstn)
      (oscillatorHalt && !transfer) |=> $stable(st_q.cnt[0]);
  endproperty
  a_haltStops: assert property (p_haltStops) else $error("time advanced while halted");

  property p_bcdRange;
    @(posedge core_clk) disable iff (!rstn)
      st_q.cnt[1][3:0] <= 4'h9 && st_q.cnt[1][6:4] <= 3'h5 && st_q.cnt[3][5:0] <= 6'h23;
  endproperty
  a_bcdRange: assert property (p_bcdRange) else $error("counter out of BCD range");

  property p_zeroBits;
    @(posedge core_clk) disable iff (!rstn)
      rdValid |-> (rdData & ~mapMask(st_q.rdAddr)) == 8'h00;
  endproperty
  a_zeroBits: assert property (p_zeroBits) else $error("fixed-zero bit read as one");

endmodule
`default_nettype wire

// *** test/rtc_register_map_variants_tb.sv ***
// Purpose: Self-checking bench of the register bank in both field maps
// Assumes: Time base shortened to 4 cycles a hundredth
// Notes:   Instance A uses the alarm-pin map, instance B the square-wave map
`default_nettype none
module rtc_register_map_variants_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 4;
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       accStart, accStop, ptrLoad, wrStrobe, rdStrobe, rdValid, v;
  logic [3:0] ptrValue;
  logic [7:0] wrData, rdDataA, rdDataB, qa, qb;
  logic       alarmMatchEvt = 1'b0;
  logic       watchdogExpireEvt = 1'b0;
  logic       oscFailEvt = 1'b0;
  logic       oscillatorHalt, oscFailIrqEnable, oscFailIrqEnableB, frequencyTest;
  logic       outputLevel, squareWaveEnable, fixedLowFreqOutputEnable, alarmPinEnable;
  logic       alarmMatchFlag, watchdogExpiredFlag, oscillatorFailFlag;
  logic [3:0] squareWaveRate;
  logic [1:0] centuryCount;
  logic [2:0] watchdogTickSelect;
  logic [4:0] watchdogCountMultiplier;
  logic [5:1] alarmRepeatMask;
  // Far-variant outputs, each judged against its own map
  logic       sqEnA, lfEnA, rdValidB, haltB, ftestB, outLvlB, pinEnB, afB, wdfB, ofB;
  logic [3:0] sqRateA;
  logic [1:0] centuryB;
  logic [2:0] wdTickB;
  logic [4:0] wdMultB;
  logic [5:1] rptB;
  int         errCount = 0;
  int         samplesChecked = 0;
  int         cycles = 0;

  rtcrb_register_bank #(.APIN_VARIANT(1'b1), .TICK_CYCLES(TICK)) rtcrb_register_bank_inst (
    .rdData(rdDataA), .squareWaveRate(sqRateA), .squareWaveEnable(sqEnA),
    .fixedLowFreqOutputEnable(lfEnA), .*);
  rtcrb_register_bank #(.APIN_VARIANT(1'b0), .TICK_CYCLES(TICK)) rtcrb_register_bank_sqw_inst (
    .rdData(rdDataB), .rdValid(rdValidB), .oscillatorHalt(haltB),
    .oscFailIrqEnable(oscFailIrqEnableB), .centuryCount(centuryB), .frequencyTest(ftestB),
    .outputLevel(outLvlB), .watchdogTickSelect(wdTickB), .watchdogCountMultiplier(wdMultB),
    .alarmPinEnable(pinEnB), .alarmRepeatMask(rptB), .alarmMatchFlag(afB),
    .watchdogExpiredFlag(wdfB), .oscillatorFailFlag(ofB), .*);
  // Valid seen by the host only when both maps answered
  rtcrb_host_model host (.*, .rdDataA(rdDataA), .rdDataB(rdDataB),
    .rdValid(rdValid & rdValidB));

  // Clock and hang guard
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      endOfTest();
    end
  end

  task automatic endOfTest();
    $display("Checks %0d, errors %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samplesChecked++;
    if (g !== e) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read one address from both maps
  task automatic rdChk(input logic [3:0] a, input logic [7:0] eA, input logic [7:0] eB);
    host.get(a, qa, qb, v);
    chk("rdValid", 8'h01, {7'h00, v});
    chk("rdDataA", eA, qa);
    chk("rdDataB", eB, qb);
  endtask

  task automatic sc_reset();
    chk("halt", 8'h00, {7'h00, oscillatorHalt});
    rdChk(4'h4, 8'h01, 8'h01);
    rdChk(4'hF, 8'h00, 8'h00);
  endtask

  // Split tick select is the awkward field
  task automatic sc_wdog();
    host.put(4'h9, 8'h0E);
    chk("wdMult", 8'h03, {3'h0, watchdogCountMultiplier});
    chk("wdTick", 8'h02, {5'h00, watchdogTickSelect});
    host.put(4'h9, 8'h83);
    chk("wdMult", 8'h00, {3'h0, watchdogCountMultiplier});
    chk("wdTick", 8'h07, {5'h00, watchdogTickSelect});
    chk("wdMultB", 8'h00, {3'h0, wdMultB});
    chk("wdTickB", 8'h07, {5'h00, wdTickB});
    rdChk(4'h9, 8'h83, 8'h83);
  endtask

  task automatic sc_repeat();
    logic [3:0] a [5] = '{4'hB, 4'hB, 4'hC, 4'hD, 4'hE};
    logic [7:0] d [5] = '{8'h41, 8'h81, 8'h80, 8'h80, 8'h80};
    logic [4:0] m [5] = '{5'h10, 5'h08, 5'h0C, 5'h0E, 5'h0F};
    for (int i = 0; i < 5; i++) begin
      host.put(a[i], d[i]);
      chk("rptMask", {3'h0, m[i]}, {3'h0, alarmRepeatMask});
      chk("rptMaskB", {3'h0, m[i]}, {3'h0, rptB});
    end
  endtask

  // Flag writes to D7 and D6 must not clear them
  task automatic sc_flags();
    @(negedge core_clk);
    {alarmMatchEvt, watchdogExpireEvt, oscFailEvt} = 3'h7;
    @(negedge core_clk);
    {alarmMatchEvt, watchdogExpireEvt, oscFailEvt} = 3'h0;
    host.put(4'hF, 8'h04);
    rdChk(4'hF, 8'hC4, 8'hC4);
    chk("af", 8'h00, {7'h00, alarmMatchFlag});
    chk("wdf", 8'h00, {7'h00, watchdogExpiredFlag});
    chk("afB", 8'h00, {7'h00, afB});
    chk("wdfB", 8'h00, {7'h00, wdfB});
    chk("ofB", 8'h01, {7'h00, ofB});
    rdChk(4'hF, 8'h04, 8'h04);
    host.put(4'hF, 8'h00);
    rdChk(4'hF, 8'h00, 8'h00);
    chk("of", 8'h00, {7'h00, oscillatorFailFlag});
    chk("ofB", 8'h00, {7'h00, ofB});
  endtask

  // Ones written into fixed zeros on purpose
  task automatic sc_map();
    logic [3:0] a [4]  = '{4'h2, 4'h4, 4'h8, 4'hA};
    logic [7:0] d [4]  = '{8'h80, 8'hF1, 8'hFF, 8'hE1};
    logic [7:0] ea [4] = '{8'h80, 8'h01, 8'hFF, 8'h81};
    logic [7:0] eb [4] = '{8'h00, 8'hF1, 8'h3F, 8'h61};
    for (int i = 0; i < 4; i++) begin
      host.put(a[i], d[i]);
      rdChk(a[i], ea[i], eb[i]);
    end
    chk("osc_fail_irq_enable", 8'h01, {7'h00, oscFailIrqEnable});
    chk("ofieB", 8'h00, {7'h00, oscFailIrqEnableB});
    chk("ftest", 8'h01, {7'h00, frequencyTest});
    chk("outLvl", 8'h01, {7'h00, outputLevel});
    chk("pinEn", 8'h01, {7'h00, alarmPinEnable});
    chk("sqRate", 8'h0F, {4'h0, squareWaveRate});
    chk("sqEn", 8'h01, {7'h00, squareWaveEnable});
    chk("lfEn", 8'h01, {7'h00, fixedLowFreqOutputEnable});
    // Fields absent from a map stay zero there
    chk("ftestB", 8'h00, {7'h00, ftestB});
    chk("outLvlB", 8'h00, {7'h00, outLvlB});
    chk("pinEnB", 8'h00, {7'h00, pinEnB});
    chk("sqRateA", 8'h00, {4'h0, sqRateA});
    chk("sqEnA", 8'h00, {7'h00, sqEnA});
    chk("lfEnA", 8'h00, {7'h00, lfEnA});
  endtask

  task automatic sc_halt();
    host.put(4'h1, 8'h80);
    chk("halt", 8'h01, {7'h00, oscillatorHalt});
    chk("haltB", 8'h01, {7'h00, haltB});
    repeat (300) @(negedge core_clk);
    rdChk(4'h0, 8'h00, 8'h00);
    rdChk(4'h1, 8'h80, 8'h80);
  endtask

  // One second after load seconds, minutes and hours wrap and the weekday steps from 1 to 2
  task automatic sc_roll();
    logic [7:0] ea [4] = '{8'h00, 8'h00, 8'h00, 8'h02};
    logic [7:0] eb [4] = '{8'h00, 8'h00, 8'h00, 8'hF2};
    host.open_acc();
    host.set_ptr(4'h1);
    host.wr(8'h59);
    host.wr(8'h59);
    host.wr(8'h23);
    host.close_acc();
    repeat (420) @(negedge core_clk);
    host.open_acc();
    host.set_ptr(4'h1);
    for (int i = 0; i < 4; i++) begin
      host.rd(qa, qb, v);
      chk("rollA", ea[i], qa);
      chk("rollB", eb[i], qb);
    end
    host.close_acc();
  endtask

  task automatic sc_century();
    host.open_acc();
    host.set_ptr(4'h6);
    host.wr(8'hC1);
    chk("century", 8'h00, {6'h00, centuryCount});
    host.close_acc();
    @(negedge core_clk);
    chk("century", 8'h03, {6'h00, centuryCount});
    chk("centuryB", 8'h03, {6'h00, centuryB});
    rdChk(4'h6, 8'hC1, 8'hC1);
  endtask

  // Running time must not leak into one access
  task automatic sc_freeze();
    logic [7:0] r;
    host.open_acc();
    host.set_ptr(4'h0);
    host.rd(qa, qb, v);
    r = qa;
    repeat (60) @(negedge core_clk);
    host.set_ptr(4'h0);
    host.rd(qa, qb, v);
    host.close_acc();
    chk("frozen", r, qa);
  endtask

  // Reset, then every scenario in turn
  initial begin
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    sc_reset();
    sc_wdog();
    sc_repeat();
    sc_flags();
    sc_map();
    sc_halt();
    sc_roll();
    sc_century();
    sc_freeze();
    endOfTest();
  end
endmodule
`default_nettype wire

// *** test/rtcrb_host_model.sv ***
// Purpose: Host side of the byte port, one serial access per call
// Assumes: Requests change at the falling edge of core_clk
// Notes:   Released data lines show the inverse of the last value
`default_nettype none
module rtcrb_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] rdDataA,
  input  wire logic [7:0] rdDataB,
  input  wire logic       rdValid,
  output var logic        accStart,
  output var logic        accStop,
  output var logic        ptrLoad,
  output var logic [3:0]  ptrValue,
  output var logic        wrStrobe,
  output var logic [7:0]  wrData,
  output var logic        rdStrobe
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle lines from time zero
  initial begin
    {accStart, accStop, ptrLoad, wrStrobe, rdStrobe} = 5'h00;
    ptrValue = 4'h0;
    wrData   = 8'h00;
  end

  // Start and stop pulses frame every access
  task automatic open_acc();
    @(negedge core_clk) accStart = 1'b1;
    @(negedge core_clk) accStart = 1'b0;
  endtask
  task automatic close_acc();
    @(negedge core_clk) accStop = 1'b1;
    @(negedge core_clk) accStop = 1'b0;
  endtask

  // Pointer load, value released right after
  task automatic set_ptr(input logic [3:0] a);
    @(negedge core_clk) ptrLoad = 1'b1;
    ptrValue = a;
    @(negedge core_clk) ptrLoad = 1'b0;
    ptrValue = ~a;
  endtask

  // Data goes out as given; callers may set fixed zeros, as sc_map does
  task automatic wr(input logic [7:0] d);
    @(negedge core_clk) wrStrobe = 1'b1;
    wrData = d;
    @(negedge core_clk) wrStrobe = 1'b0;
    wrData = ~d;
  endtask

  // Answer stands one cycle after the strobe edge
  task automatic rd(output logic [7:0] qa, output logic [7:0] qb, output logic v);
    @(negedge core_clk) rdStrobe = 1'b1;
    @(negedge core_clk) rdStrobe = 1'b0;
    v  = rdValid;
    qa = rdDataA;
    qb = rdDataB;
  endtask

  // Whole single-byte accesses
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    open_acc();
    set_ptr(a);
    wr(d);
    close_acc();
    @(negedge core_clk);
  endtask
  task automatic get(input logic [3:0] a, output logic [7:0] qa, output logic [7:0] qb,
                     output logic v);
    open_acc();
    set_ptr(a);
    rd(qa, qb, v);
    close_acc();
  endtask
endmodule
`default_nettype wire
